// ---- sbst_device.sv ----
// Purpose: Secure board power-up self-test sequencer.
// Assumes: External RAM samples addr/we/re on a rising edge, rdata valid the cycle after.
// Notes: External and audio tests live outside; this block only starts them.
module sbst_device #(
	parameter int WDOG_CYC = sbst_pkg::DEV_WDOG_CYC,
	parameter int IRQ_WAIT = sbst_pkg::IRQ_WAIT_CYC,
	parameter int FLASH_ON = sbst_pkg::FLASH_ON_CYC,
	parameter int FLASH_OFF = sbst_pkg::FLASH_OFF_CYC
) (
	input wire logic clk_sys,
	input wire logic nrst,
	sbst_link_if.dev lnk,
	input wire logic rx_irq,
	input wire logic tx_irq,
	input wire logic [7:0] mux_data,
	output logic [7:0] xram_addr,
	output logic [7:0] xram_wdata,
	output logic xram_we,
	output logic xram_re,
	input wire logic [7:0] xram_rdata,
	input wire logic [7:0] iram_stuck,
	output logic ext_test_start,
	input wire logic ext_test_done,
	output logic tx_code_detect_indicator_led,
	output logic rx_code_detect_indicator_led,
	output logic rx_code_detect_indicator_start,
	output logic tx_code_detect_indicator_start,
	output logic link_poll,
	output logic [15:0] sys_timer,
	output logic mux_rd,
	output logic [7:0] mux_rd_data,
	output logic [15:0] sci_baud_div,
	output logic [7:0] sci_frame,
	output logic own_wdog_reset
);
	sbst_pkg::sbst_dev_state_t state;
	logic h1, hard_rst_n, s1, rst_n, wdog_rst, wdog_armed;
	logic [31:0] wdog_cnt, tmr;
	logic [9:0] pin_s1, pin_s2;
	logic [1:0] irq_d;
	logic rx_edge, tx_edge, irq_en, rx_seen, tx_seen;
	logic [2:0] sub;
	logic [3:0] idx, qcnt, qidx;
	logic [7:0] iram [16];
	logic fail_led, flash_start, flash_led, flash_done;
	logic [2:0] flash_cnt;
	wire hard_arst_n = nrst & lnk.exp_rst_n;
	wire soft_arst_n = hard_rst_n & ~wdog_rst;
	wire wdog_fire = wdog_armed && (wdog_cnt == 32'(WDOG_CYC - 1));

	function automatic logic [7:0] qaddr(input logic [3:0] i);
		qaddr = sbst_pkg::QUEUE_BASE + {4'h0, i};
	endfunction

	// Hard reset comes only from power or the controller line
	always_ff @(posedge clk_sys or negedge hard_arst_n) begin
		if (!hard_arst_n) begin
			h1 <= 1'b0;
			hard_rst_n <= 1'b0;
		end else begin
			h1 <= 1'b1;
			hard_rst_n <= h1;
		end
	end

	always_ff @(posedge clk_sys or negedge soft_arst_n) begin
		if (!soft_arst_n) begin
			s1 <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			s1 <= 1'b1;
			rst_n <= s1;
		end
	end

	// Survives the watchdog's own reset so later tests know the cause
	always_ff @(posedge clk_sys or negedge hard_rst_n) begin
		if (!hard_rst_n) begin
			wdog_rst <= 1'b0;
			own_wdog_reset <= 1'b0;
		end else begin
			wdog_rst <= wdog_fire;
			if (wdog_rst) begin
				own_wdog_reset <= 1'b1;
			end
		end
	end

	// Serviced everywhere except while reporting by lamp (S_FLASH) and while halted (S_HALT)
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wdog_cnt <= 32'h0000_0000;
		end else if (!wdog_armed || (state != sbst_pkg::S_FLASH && state != sbst_pkg::S_HALT)) begin
			wdog_cnt <= 32'h0000_0000;
		end else if (!wdog_fire) begin
			wdog_cnt <= wdog_cnt + 32'h0000_0001;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1 <= 10'h000;
			pin_s2 <= 10'h000;
			irq_d <= 2'h0;
		end else begin
			pin_s1 <= {rx_irq, tx_irq, mux_data};
			pin_s2 <= pin_s1;
			irq_d <= pin_s2[9:8];
		end
	end
	assign rx_edge = pin_s2[9] & ~irq_d[1];
	assign tx_edge = pin_s2[8] & ~irq_d[0];

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rx_code_detect_indicator_start <= 1'b0;
			link_poll <= 1'b0;
			sys_timer <= 16'h0000;
			tx_code_detect_indicator_start <= 1'b0;
			mux_rd <= 1'b0;
			mux_rd_data <= 8'h00;
		end else begin
			rx_code_detect_indicator_start <= irq_en & rx_edge;
			link_poll <= irq_en & rx_edge;
			if (irq_en && rx_edge) begin
				sys_timer <= sys_timer + 16'h0001;
			end
			tx_code_detect_indicator_start <= irq_en & tx_edge;
			mux_rd <= irq_en & tx_edge;
			if (irq_en && tx_edge) begin
				mux_rd_data <= pin_s2[7:0];
			end
		end
	end

	// On-chip RAM kept out of the reset process: contents are not reset
	always_ff @(posedge clk_sys) begin
		if (state == sbst_pkg::S_IRAM && sub == 3'h0) begin
			iram[idx] <= sbst_pkg::ALL_ONES;
		end else if (state == sbst_pkg::S_IRAM && sub == 3'h2) begin
			iram[idx] <= sbst_pkg::ALL_ZERO;
		end
	end

	sbst_flasher #(.ON_CYC(FLASH_ON), .OFF_CYC(FLASH_OFF)) u_flash (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.start(flash_start),
		.count(flash_cnt),
		.led(flash_led),
		.done(flash_done)
	);

	assign lnk.fail_led = fail_led | flash_led;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state <= sbst_pkg::S_INIT;
			fail_led <= 1'b1;
			wdog_armed <= 1'b0;
			sci_baud_div <= 16'h0000;
			sci_frame <= 8'h00;
			tx_code_detect_indicator_led <= 1'b0;
			rx_code_detect_indicator_led <= 1'b0;
			xram_addr <= 8'h00;
			xram_wdata <= 8'h00;
			xram_we <= 1'b0;
			xram_re <= 1'b0;
			sub <= 3'h0;
			idx <= 4'h0;
			qcnt <= 4'h0;
			qidx <= 4'h0;
			tmr <= 32'h0000_0000;
			irq_en <= 1'b0;
			rx_seen <= 1'b0;
			tx_seen <= 1'b0;
			flash_start <= 1'b0;
			flash_cnt <= 3'h0;
			ext_test_start <= 1'b0;
			lnk.code_valid <= 1'b0;
			lnk.code <= 8'h00;
		end else begin
			xram_we <= 1'b0;
			xram_re <= 1'b0;
			flash_start <= 1'b0;
			ext_test_start <= 1'b0;
			case (state)
				sbst_pkg::S_INIT: begin
					wdog_armed <= 1'b1;
					sci_baud_div <= sbst_pkg::SCI_BAUD_DIV;
					sci_frame <= sbst_pkg::SCI_FRAME;
					state <= sbst_pkg::S_LAMP;
				end
				sbst_pkg::S_LAMP: begin
					tx_code_detect_indicator_led <= 1'b1;
					rx_code_detect_indicator_led <= 1'b1;
					xram_addr <= 8'h00;
					sub <= 3'h0;
					state <= sbst_pkg::S_XRAM;
				end
				sbst_pkg::S_XRAM: begin
					case (sub)
						3'h0, 3'h3: begin
							if (sub == 3'h3 && xram_rdata != sbst_pkg::ALL_ONES) begin
								flash_cnt <= sbst_pkg::FLASH_XRAM;
								flash_start <= 1'b1;
								state <= sbst_pkg::S_FLASH;
							end else begin
								xram_we <= 1'b1;
								xram_wdata <= (sub == 3'h0) ? sbst_pkg::ALL_ONES : sbst_pkg::ALL_ZERO;
								sub <= sub + 3'h1;
							end
						end
						3'h1, 3'h4: begin
							xram_re <= 1'b1;
							sub <= sub + 3'h1;
						end
						3'h6: begin
							if (xram_rdata != sbst_pkg::ALL_ZERO) begin
								flash_cnt <= sbst_pkg::FLASH_XRAM;
								flash_start <= 1'b1;
								state <= sbst_pkg::S_FLASH;
							end else if (xram_addr == sbst_pkg::XRAM_LAST) begin
								irq_en <= 1'b1;
								tmr <= 32'h0000_0000;
								state <= sbst_pkg::S_IRQ;
							end else begin
								xram_addr <= xram_addr + 8'h01;
								sub <= 3'h0;
							end
						end
						default: begin
							sub <= sub + 3'h1;
						end
					endcase
				end
				sbst_pkg::S_IRQ: begin
					rx_seen <= rx_seen | rx_edge;
					tx_seen <= tx_seen | tx_edge;
					tmr <= tmr + 32'h0000_0001;
					if (rx_seen && tx_seen) begin
						idx <= 4'h0;
						sub <= 3'h0;
						state <= sbst_pkg::S_IRAM;
					end else if (tmr == 32'(IRQ_WAIT - 1)) begin
						flash_cnt <= sbst_pkg::FLASH_IRQ;
						flash_start <= 1'b1;
						state <= sbst_pkg::S_FLASH;
					end
				end
				sbst_pkg::S_IRAM: begin
					case (sub)
						3'h0: begin
							sub <= 3'h1;
						end
						3'h2: begin
							sub <= 3'h3;
						end
						default: begin
							if ((iram[idx] & ~iram_stuck) != ((sub == 3'h1) ? sbst_pkg::ALL_ONES : sbst_pkg::ALL_ZERO)) begin
								xram_addr <= qaddr(qcnt);
								xram_wdata <= sbst_pkg::ERR_IRAM;
								xram_we <= 1'b1;
								qcnt <= qcnt + 4'h1;
								state <= sbst_pkg::S_LINK;
							end else if (sub == 3'h1) begin
								sub <= 3'h2;
							end else if (idx == sbst_pkg::IRAM_LAST) begin
								state <= sbst_pkg::S_LINK;
							end else begin
								idx <= idx + 4'h1;
								sub <= 3'h0;
							end
						end
					endcase
				end
				sbst_pkg::S_LINK: begin
					if (lnk.link_alive) begin
						qidx <= 4'h0;
						sub <= 3'h0;
						state <= sbst_pkg::S_SEND;
					end
				end
				sbst_pkg::S_SEND: begin
					case (sub)
						3'h0: begin
							if (qidx == qcnt) begin
								state <= sbst_pkg::S_EXT;
							end else begin
								xram_addr <= qaddr(qidx);
								xram_re <= 1'b1;
								sub <= 3'h1;
							end
						end
						3'h1: begin
							sub <= 3'h2;
						end
						3'h2: begin
							lnk.code <= xram_rdata;
							lnk.code_valid <= 1'b1;
							sub <= 3'h3;
						end
						default: begin
							if (lnk.code_ready) begin
								lnk.code_valid <= 1'b0;
								qidx <= qidx + 4'h1;
								sub <= 3'h0;
							end
						end
					endcase
				end
				sbst_pkg::S_EXT: begin
					if (own_wdog_reset) begin
						state <= sbst_pkg::S_BG;
					end else if (sub == 3'h0) begin
						ext_test_start <= 1'b1;
						sub <= 3'h1;
					end else if (ext_test_done) begin
						state <= sbst_pkg::S_BG;
					end
				end
				sbst_pkg::S_BG: begin
					fail_led <= 1'b0;
				end
				sbst_pkg::S_FLASH: begin
					// Hand the lamp over only once the flasher lights it, so no false blink
					if (flash_led) begin
						fail_led <= 1'b0;
					end
					if (flash_done && !flash_start) begin
						state <= sbst_pkg::S_HALT;
					end
				end
				default: begin
					// Halt forever; only the watchdog or a hard reset gets us out
					state <= sbst_pkg::S_HALT;
				end
			endcase
		end
	end
endmodule // sbst_device

// ---- sbst_pkg.sv ----
// Purpose: Shared constants and types for the secure board self-test sequencer and its station controller.
// Assumes: One 125 MHz clock for both ends.
// Notes: Long counts are defaults for top-level parameters.
package sbst_pkg;
	localparam int CLK_MHZ = 125;
	localparam int DEV_WDOG_MS = 16;
	localparam int DEV_WDOG_CYC = DEV_WDOG_MS * CLK_MHZ * 1000;
	localparam int FLASH_ON_MS = 250;
	localparam int FLASH_ON_CYC = FLASH_ON_MS * CLK_MHZ * 1000;
	localparam int FLASH_OFF_MS = 250;
	localparam int FLASH_OFF_CYC = FLASH_OFF_MS * CLK_MHZ * 1000;
	localparam int IRQ_PERIOD_US = 667;
	localparam int IRQ_WAIT_CYC = 3 * IRQ_PERIOD_US * CLK_MHZ;
	localparam int DISP_S = 5;
	localparam int DISP_CYC = DISP_S * CLK_MHZ * 1000000;
	localparam int CTL_WDOG_MS = 100;
	localparam int CTL_WDOG_CYC = CTL_WDOG_MS * CLK_MHZ * 1000;
	localparam int HOLD_MIN_MS = 10;
	localparam int HOLD_MIN_CYC = HOLD_MIN_MS * CLK_MHZ * 1000;
	localparam logic [7:0] XRAM_LAST = 8'hFF;
	localparam logic [3:0] IRAM_LAST = 4'hF;
	localparam logic [7:0] QUEUE_BASE = 8'hF0;
	localparam logic [7:0] ALL_ONES = 8'hFF;
	localparam logic [7:0] ALL_ZERO = 8'h00;
	localparam int ERR_FATAL_BIT = 7;
	localparam logic [7:0] ERR_IRAM = 8'h83;
	localparam logic [2:0] FLASH_XRAM = 3'h4;
	localparam logic [2:0] FLASH_IRQ = 3'h2;
	localparam logic [15:0] SCI_BAUD_DIV = 16'h0100;
	localparam logic [7:0] SCI_FRAME = 8'h01;

	typedef enum logic [10:0] {
		S_INIT = 11'h001,
		S_LAMP = 11'h002,
		S_XRAM = 11'h004,
		S_IRQ = 11'h008,
		S_IRAM = 11'h010,
		S_LINK = 11'h020,
		S_SEND = 11'h040,
		S_EXT = 11'h080,
		S_BG = 11'h100,
		S_FLASH = 11'h200,
		S_HALT = 11'h400
	} sbst_dev_state_t;

	typedef enum logic [3:0] {
		C_HOLD = 4'h1,
		C_RUN = 4'h2,
		C_SHOW = 4'h4,
		C_STALL = 4'h8
	} sbst_ctl_state_t;
endpackage

// ---- sbst_link_if.sv ----
// Purpose: Link between the secure board and the station controller.
// Assumes: Both ends on clk_sys.
// Notes: code_valid holds until code_ready is seen high.
interface sbst_link_if;
	logic exp_rst_n;
	logic fail_led;
	logic code_valid;
	logic [7:0] code;
	logic code_ready;
	logic link_alive;
	modport dev (input exp_rst_n, input code_ready, input link_alive, output fail_led, output code_valid, output code);
	modport ctl (output exp_rst_n, output code_ready, output link_alive, input fail_led, input code_valid, input code);
endinterface

// ---- sbst_flasher.sv ----
// Purpose: Flash a lamp a given number of times.
// Assumes: start is a one-cycle pulse.
// Notes: An off interval follows the last flash before done rises.
module sbst_flasher #(
	parameter int ON_CYC = sbst_pkg::FLASH_ON_CYC,
	parameter int OFF_CYC = sbst_pkg::FLASH_OFF_CYC
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [2:0] count,
	output logic led,
	output logic done
);
	logic [31:0] tmr;
	logic [2:0] left;
	logic busy;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tmr <= 32'h0000_0000;
			left <= 3'h0;
			busy <= 1'b0;
			led <= 1'b0;
			done <= 1'b0;
		end else if (start) begin
			tmr <= 32'h0000_0000;
			left <= count;
			busy <= 1'b1;
			led <= 1'b1;
			done <= 1'b0;
		end else if (busy) begin
			if (tmr == 32'(led ? ON_CYC - 1 : OFF_CYC - 1)) begin
				tmr <= 32'h0000_0000;
				if (led) begin
					led <= 1'b0;
					left <= left - 3'h1;
				end else if (left == 3'h0) begin
					busy <= 1'b0;
					done <= 1'b1;
				end else begin
					led <= 1'b1;
				end
			end else begin
				tmr <= tmr + 32'h0000_0001;
			end
		end
	end
endmodule // sbst_flasher

// ---- sbst_host.sv ----
// Purpose: Station controller end of the secure board link.
// Assumes: ctl_diag_done is high once the controller's own tests pass.
// Notes: Its own watchdog expiry is modelled as a stall then a re-hold.
module sbst_host #(
	parameter int HOLD_MIN = sbst_pkg::HOLD_MIN_CYC,
	parameter int DISP = sbst_pkg::DISP_CYC,
	parameter int CTL_WDOG = sbst_pkg::CTL_WDOG_CYC
) (
	input wire logic clk_sys,
	input wire logic nrst,
	sbst_link_if.ctl lnk,
	input wire logic ctl_diag_done,
	output logic secure_fail_led,
	output logic disp_valid,
	output logic [7:0] disp_code,
	output logic disp_fatal
);
	sbst_pkg::sbst_ctl_state_t state;
	logic [31:0] tmr;
	logic run;

	assign lnk.exp_rst_n = run;
	assign lnk.link_alive = run;
	assign lnk.code_ready = (state == sbst_pkg::C_RUN);
	assign secure_fail_led = ~run | lnk.fail_led;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state <= sbst_pkg::C_HOLD;
			tmr <= 32'h0000_0000;
			run <= 1'b0;
			disp_valid <= 1'b0;
			disp_code <= 8'h00;
			disp_fatal <= 1'b0;
		end else begin
			case (state)
				sbst_pkg::C_HOLD: begin
					if (tmr < 32'(HOLD_MIN - 1)) begin
						tmr <= tmr + 32'h0000_0001;
					end else if (ctl_diag_done) begin
						run <= 1'b1;
						state <= sbst_pkg::C_RUN;
					end
				end
				sbst_pkg::C_RUN: begin
					if (lnk.code_valid) begin
						disp_valid <= 1'b1;
						disp_code <= lnk.code;
						disp_fatal <= lnk.code[sbst_pkg::ERR_FATAL_BIT];
						tmr <= 32'h0000_0000;
						state <= sbst_pkg::C_SHOW;
					end
				end
				sbst_pkg::C_SHOW: begin
					tmr <= tmr + 32'h0000_0001;
					if (tmr == 32'(DISP - 1)) begin
						tmr <= 32'h0000_0000;
						// Non-fatal stays shown until the next code
						state <= disp_fatal ? sbst_pkg::C_STALL : sbst_pkg::C_RUN;
					end
				end
				default: begin
					tmr <= tmr + 32'h0000_0001;
					if (tmr == 32'(CTL_WDOG - 1)) begin
						tmr <= 32'h0000_0000;
						run <= 1'b0;
						disp_valid <= 1'b0;
						state <= sbst_pkg::C_HOLD;
					end
				end
			endcase
		end
	end
endmodule // sbst_host

// ---- sbst_link_properties.sv ----
// Purpose: Protocol checks on the link between secure board and host.
// Assumes: One clk_sys domain, nrst async active low.
// Notes: Host show and stall counts arrive as parameters.
module sbst_link_properties #(
	parameter int DISP = 50,
	parameter int CTL_WDOG = 30
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic exp_rst_n,
	input wire logic fail_led,
	input wire logic code_valid,
	input wire logic [7:0] code,
	input wire logic code_ready,
	input wire logic link_alive
);
	// Margin covers state hand-off latency in the host
	localparam int RST_LO = DISP + CTL_WDOG - 6;
	localparam int RST_HI = DISP + CTL_WDOG + 10;
	logic hs;
	assign hs = code_valid && code_ready;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	property p_lamp_hold;
		!exp_rst_n [*4] |-> fail_led;
	endproperty
	property p_quiet_hold;
		!exp_rst_n [*4] |-> !code_valid && !code_ready;
	endproperty
	property p_code_wait;
		code_valid && !code_ready && exp_rst_n |=> code_valid && $stable(code);
	endproperty
	property p_code_gap;
		hs |=> !code_valid [*3];
	endproperty
	property p_show;
		hs |=> !code_ready;
	endproperty
	property p_lamp_send;
		code_valid |-> fail_led;
	endproperty
	property p_code_val;
		code_valid |-> code == sbst_pkg::ERR_IRAM && code[7];
	endproperty
	property p_link_first;
		code_valid |-> link_alive;
	endproperty
	property p_fatal_reset;
		hs && code[7] |-> ##[RST_LO:RST_HI] !exp_rst_n;
	endproperty
	a_lamp_hold: assert property (p_lamp_hold) else $error("lamp dark in hold");
	a_quiet_hold: assert property (p_quiet_hold) else $error("link busy in hold");
	a_code_wait: assert property (p_code_wait) else $error("code dropped early");
	a_code_gap: assert property (p_code_gap) else $error("codes too close");
	a_show: assert property (p_show) else $error("host still ready");
	a_lamp_send: assert property (p_lamp_send) else $error("lamp off while sending");
	a_code_val: assert property (p_code_val) else $error("bad code value");
	a_link_first: assert property (p_link_first) else $error("code before link");
	a_fatal_reset: assert property (p_fatal_reset) else $error("no reset after fatal");
	c_hs: cover property (hs ##1 !code_ready);
	c_lamp_off: cover property ($fell(fail_led));
	c_release: cover property ($rose(exp_rst_n));
endmodule // sbst_link_properties

// ---- secure_board_selftest_sequencer_tb_top.sv ----
// Purpose: Self-checking bench, both link ends facing each other.
// Assumes: Counts shortened through parameters.
// Notes: Faults injected via RAM model and interrupt pins.
module secure_board_selftest_sequencer_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int DISP = 50;
	localparam int CTL_WDOG = 30;
	logic clk_sys = 0;
	logic nrst = 0;
	logic rx_irq = 0;
	logic tx_irq = 0;
	logic tx_en = 1;
	logic ctl_diag_done = 0;
	logic ext_test_done = 0;
	logic hs = 0;
	logic [7:0] mux_data = 8'h00;
	logic [7:0] iram_stuck = 8'h00;
	logic [7:0] xbad = 8'h00;
	logic [7:0] xram_rdata = 8'h00;
	logic [7:0] mem [256];
	logic [7:0] xram_addr, xram_wdata, disp_code, mux_rd_data, sci_frame;
	logic [15:0] sci_baud_div;
	logic xram_we, xram_re, ext_test_start, tx_code_detect_indicator_led, rx_code_detect_indicator_led, own_wdog_reset, secure_fail_led, disp_fatal;
	logic rx_code_detect_indicator_start, tx_code_detect_indicator_start, link_poll, mux_rd, disp_valid;
	logic [15:0] sys_timer;
	logic [15:0] st_last = 16'h0000;
	logic [2:0] rx_rise = 3'h0;
	logic [2:0] tx_rise = 3'h0;
	logic rx_prev = 0;
	logic tx_prev = 0;
	integer seed = 32'h952e;
	int n_errors = 0;
	int checks_done = 0;
	int n_fall = 0;
	int n_ext = 0;
	logic [7:0] eq [$];
	sbst_link_if lnk ();
	sbst_device #(.WDOG_CYC(400), .IRQ_WAIT(200), .FLASH_ON(20), .FLASH_OFF(20)) u_sbst_device (
		.clk_sys(clk_sys), .nrst(nrst), .lnk(lnk.dev), .rx_irq(rx_irq), .tx_irq(tx_irq), .mux_data(mux_data),
		.xram_addr(xram_addr), .xram_wdata(xram_wdata), .xram_we(xram_we), .xram_re(xram_re),
		.xram_rdata(xram_rdata), .iram_stuck(iram_stuck), .ext_test_start(ext_test_start),
		.ext_test_done(ext_test_done), .tx_code_detect_indicator_led(tx_code_detect_indicator_led), .rx_code_detect_indicator_led(rx_code_detect_indicator_led), .rx_code_detect_indicator_start(rx_code_detect_indicator_start),
		.tx_code_detect_indicator_start(tx_code_detect_indicator_start), .link_poll(link_poll), .sys_timer(sys_timer), .mux_rd(mux_rd),
		.mux_rd_data(mux_rd_data),
		.sci_baud_div(sci_baud_div), .sci_frame(sci_frame), .own_wdog_reset(own_wdog_reset));
	sbst_host #(.HOLD_MIN(10), .DISP(DISP), .CTL_WDOG(CTL_WDOG)) u_sbst_host (
		.clk_sys(clk_sys), .nrst(nrst), .lnk(lnk.ctl), .ctl_diag_done(ctl_diag_done),
		.secure_fail_led(secure_fail_led), .disp_valid(disp_valid), .disp_code(disp_code), .disp_fatal(disp_fatal));
	sbst_link_properties #(.DISP(DISP), .CTL_WDOG(CTL_WDOG)) u_sbst_link_properties (
		.clk_sys(clk_sys), .nrst(nrst), .exp_rst_n(lnk.exp_rst_n), .fail_led(lnk.fail_led),
		.code_valid(lnk.code_valid), .code(lnk.code), .code_ready(lnk.code_ready), .link_alive(lnk.link_alive));
	always #4 clk_sys = ~clk_sys;
	task finish_test();
		$display("Checks %0d, errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	function automatic logic cond(input int k);
		case (k)
			0: return lnk.fail_led === 1'b0;
			1: return own_wdog_reset === 1'b1;
			2: return lnk.exp_rst_n === 1'b0;
			default: return eq.size() == 0;
		endcase
	endfunction
	task wait_on(input int k);
		int i;
		for (i = 0; i < 20000 && !cond(k); i++) begin
			@(posedge clk_sys);
			#1;
		end
		check(cond(k), 1'b1);
	endtask
	task hard_reset();
		@(posedge clk_sys);
		#1 nrst = 0;
		mux_data = 8'($random(seed));
		repeat (3) @(posedge clk_sys);
		#1 nrst = 1;
		n_fall = 0;
	endtask
	task check_bg(input int ext, input logic wd);
		wait_on(0);
		check(secure_fail_led, 1'b0);
		check({tx_code_detect_indicator_led, rx_code_detect_indicator_led}, 2'b11);
		check(sci_baud_div, sbst_pkg::SCI_BAUD_DIV);
		check(sci_frame, sbst_pkg::SCI_FRAME);
		check(n_ext, ext);
		check(own_wdog_reset, wd);
		check(mux_rd_data, mux_data);
		check(sys_timer > 16'h0000, 1'b1);
		check(eq.size(), 0);
	endtask
	task flash_case(input logic [7:0] bad, input logic txon, input int nf);
		int e;
		e = n_ext;
		xbad = bad;
		tx_en = txon;
		hard_reset();
		wait_on(1);
		check(n_fall, nf);
		xbad = 8'h00;
		tx_en = 1;
		check_bg(e, 1'b1);
	endtask
	// Registered RAM, byte 0x5a may carry stuck-low bits
	always @(posedge clk_sys) begin
		if (xram_we) mem[xram_addr] <= xram_wdata;
		if (xram_re) xram_rdata <= #1 mem[xram_addr] & ~(xram_addr == 8'h5a ? xbad : 8'h00);
		if (ext_test_start) n_ext <= n_ext + 1;
		ext_test_done <= #1 ext_test_done | ext_test_start;
	end
	// Every taken code is matched against the expected queue
	always @(posedge clk_sys) begin
		logic [7:0] e;
		if (hs) begin
			check(eq.size() > 0, 1'b1);
			if (eq.size() > 0) begin
				e = eq.pop_front();
				check(disp_code, e);
				check(disp_fatal, e[sbst_pkg::ERR_FATAL_BIT]);
				check(disp_valid, 1'b1);
			end
		end
		hs = nrst && lnk.code_valid === 1'b1 && lnk.code_ready === 1'b1;
	end
	always @(negedge lnk.fail_led) n_fall++;
	// Each decoded pulse must trail a pin rise by the three-flop pipeline
	always @(posedge clk_sys) begin
		if (rx_code_detect_indicator_start === 1'b1) begin
			check(rx_rise[2], 1'b1);
			check(link_poll, 1'b1);
			check(sys_timer, st_last + 16'h0001);
		end
		if (tx_code_detect_indicator_start === 1'b1) begin
			check(tx_rise[2], 1'b1);
			check(mux_rd, 1'b1);
		end
		rx_rise = {rx_rise[1:0], rx_irq & ~rx_prev};
		tx_rise = {tx_rise[1:0], tx_irq & ~tx_prev};
		rx_prev = rx_irq;
		tx_prev = tx_irq;
		st_last = sys_timer;
	end
	always begin
		repeat (50) @(posedge clk_sys);
		#1 rx_irq = 1;
		tx_irq = tx_en;
		repeat (5) @(posedge clk_sys);
		#1 rx_irq = 0;
		tx_irq = 0;
	end
	initial begin
		int i;
		int e;
		repeat (10) @(posedge clk_sys);
		#1 nrst = 1;
		repeat (20) @(posedge clk_sys);
		#1;
		check({lnk.exp_rst_n, secure_fail_led}, 2'b01);
		ctl_diag_done = 1;
		check_bg(1, 1'b0);
		for (i = 0; i < 256; i++) check(mem[i], 8'h00);
		e = n_ext;
		iram_stuck = 8'($random(seed)) | 8'h01;
		repeat (2) eq.push_back(sbst_pkg::ERR_IRAM);
		hard_reset();
		wait_on(3);
		check(own_wdog_reset, 1'b0);
		iram_stuck = 8'h00;
		wait_on(2);
		check_bg(e + 3, 1'b0);
		flash_case(8'h01 << ($unsigned($random(seed)) % 8), 1'b1, 4);
		flash_case(8'h00, 1'b0, 2);
		finish_test();
	end
	// Full run needs about 15k cycles
	initial begin
		#(8 * 60000);
		n_errors++;
		finish_test();
	end
endmodule // secure_board_selftest_sequencer_tb_top
